// >>> sfl_params.svh
// Purpose: shared constants for the serial flash device and its host controller
// Assumes: included by bare name from the device, host and bench files
// Notes: times are in microseconds except SFL_HALF_SCLK, which counts sys_clk cycles; other cycle counts derive from SFL_CLK_MHZ
// Behaviour
// - fast read: opcode, 24-bit address, dummy, rising-edge sampling
// - read data shifted out on falling clock edges
// - read address increments per byte, wraps to zero
// - chip select high ends read, output released
// - fast read refused while a cycle runs
// - program/erase need write-unlock latch set earlier
// - page program: opcode, three address bytes, data
// - program data wraps within the same page
// - over 256 bytes: last 256 are programmed
// - under 256 bytes: other page bytes untouched
// - page program needs chip select on byte boundary
// - commit starts self-timed cycle, busy flag set
// - write-unlock latch cleared before cycle ends
// - protected page is never programmed
// - small erase sets the addressed sector to ones
// - erase needs chip select right after address
// - protected sector is never erased
// - large erase sets the addressed block to ones
// - protected block is never erased
// - chip erase: bare opcode, two codes, eight bits
// - chip erase only when protect field zero
// - host keeps chip select low whole frame
// - latch clear refuses program and erase
`ifndef SFL_PARAMS_SVH
`define SFL_PARAMS_SVH

// opcodes
`define SFL_OP_FAST_READ     8'h0b
`define SFL_OP_PAGE_WRITE    8'h02
`define SFL_OP_SMALL_ERASE   8'h20
`define SFL_OP_LARGE_ERASE   8'hd8
`define SFL_OP_CHIP_ERASE_A  8'hc7
`define SFL_OP_CHIP_ERASE_B  8'h60
`define SFL_OP_WRITE_UNLOCK  8'h06

// geometry
`define SFL_ADDR_W           20
`define SFL_PAGE_BITS        8
`define SFL_SECTOR_BITS      12
`define SFL_BLOCK_BITS       16
`define SFL_ERASED_BYTE      8'hff

// timing
`define SFL_CLK_MHZ          50
`define SFL_PROG_TIME_US     1000
`define SFL_SMALL_TIME_US    1000
`define SFL_LARGE_TIME_US    1000
`define SFL_CHIP_TIME_US     1000
`define SFL_HALF_SCLK        4

// host register byte offsets and fields
`define SFL_REG_CMD          8'h00
`define SFL_REG_ADDR         8'h04
`define SFL_REG_TXDATA       8'h08
`define SFL_REG_RXDATA       8'h0c
`define SFL_REG_END          8'h10
`define SFL_REG_STATUS       8'h14
`define SFL_CMD_WITH_ADDR    8
`define SFL_CMD_WITH_DUMMY   9
`define SFL_STAT_IN_FRAME    0

`endif

// >>> sfl_pkg.sv
// Purpose: types shared by the flash device and host controller
// Assumes: nothing
// Notes: state codes are left to the tools
package sfl_pkg;
  typedef enum logic [2:0] {
    DS_CMD, DS_ADDR, DS_DUMMY, DS_READ, DS_DATA, DS_TAIL, DS_SKIP
  } sfl_dev_state_t;

  typedef enum logic [1:0] {
    OP_PROG, OP_SMALL, OP_LARGE, OP_CHIP
  } sfl_op_kind_t;

  typedef enum logic [1:0] {
    HS_IDLE, HS_SHIFT, HS_HOLD, HS_END
  } sfl_host_state_t;
endpackage

// >>> sfl_if.sv
// Purpose: four-wire serial link between host controller and flash device
// Assumes: the bench resolves the data-out wire from serialOutOeN
// Notes: serialOutOeN is low while the device drives serialOut
`timescale 1ns/1ps
`default_nettype none
interface sfl_if;
  logic csN;           // chip select, active low
  logic sclk;          // serial clock from host
  logic serialIn;      // host to device data
  logic serialOut;     // device to host data
  logic serialOutOeN;  // device output enable, active low

  modport device (input csN, input sclk, input serialIn, output serialOut, output serialOutOeN);
  modport host (output csN, output sclk, output serialIn, input serialOut, input serialOutOeN);
endinterface
`default_nettype wire

// >>> sfl_device.sv
// Purpose: serial NOR flash device: fast read, page program, erases, busy cycle
// Assumes: link pins are asynchronous to sys_clk; sclk half period >= 4 sys_clk
// Notes: array content is not reset; erase or load it before the first read
//
// The address map and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "sfl_params.svh"
module sfl_device
  import sfl_pkg::*;
#(
  parameter int ADDR_W              = `SFL_ADDR_W,
  parameter int PROG_TIME_US        = `SFL_PROG_TIME_US,
  parameter int SMALL_TIME_US       = `SFL_SMALL_TIME_US,
  parameter int LARGE_TIME_US       = `SFL_LARGE_TIME_US,
  parameter int CHIP_TIME_US        = `SFL_CHIP_TIME_US
) (
  input  wire logic       sys_clk,          // system clock
  input  wire logic       reset_n,          // async reset, active low
  sfl_if.device           link,             // serial link
  input  wire logic [2:0] protectRange,     // protect_range_field
  output logic            busyFlag,         // busy_flag, self-timed cycle running
  output logic            writeUnlockLatch  // write_unlock_latch
);
  localparam int PAGE = 1 << `SFL_PAGE_BITS;
  localparam int PROG_CYC  = PROG_TIME_US * `SFL_CLK_MHZ;
  localparam int SMALL_CYC = SMALL_TIME_US * `SFL_CLK_MHZ;
  localparam int LARGE_CYC = LARGE_TIME_US * `SFL_CLK_MHZ;
  localparam int CHIP_CYC  = CHIP_TIME_US * `SFL_CLK_MHZ;
  localparam int SWEEP_N   = 16;  // bytes swept per clock, keeps long erases short
  initial begin
    if (ADDR_W < `SFL_BLOCK_BITS || ADDR_W > 24)
      $error("ADDR_W must lie between block size bits and 24");
    if (PROG_TIME_US < 1 || SMALL_TIME_US < 1 || LARGE_TIME_US < 1 || CHIP_TIME_US < 1)
      $error("cycle times must be at least one microsecond");
  end
  // protection: field n covers the top 2^(n-1) blocks, 7 covers all
  function automatic logic isProtected(input logic [2:0] bp, input logic [ADDR_W-1:0] a);
    if (bp == 3'h0)
      return 1'b0;
    return (bp == 3'h7) || (int'(a >> `SFL_BLOCK_BITS) >=
            (1 << (ADDR_W - `SFL_BLOCK_BITS)) - (1 << (int'(bp) - 1)));
  endfunction
  logic [7:0]        mem [0:(1<<ADDR_W)-1];  // flash array
  logic [7:0]        pageBuf [0:PAGE-1];     // latched program data
  logic [PAGE-1:0]   pageValid;              // bytes received this frame
  logic [1:0]        csSync;
  logic [1:0]        sclkSync;
  logic [1:0]        sinSync;
  logic              sclkPrev;
  logic              csPrev;
  sfl_dev_state_t    state;
  logic [2:0]        bitCnt;
  logic [6:0]        shiftIn;
  logic [7:0]        opcode;
  logic [23:0]       addr;
  logic [1:0]        addrCnt;
  logic [7:0]        col;
  logic              dataSeen;
  logic [7:0]        rdByte;
  logic [2:0]        outCnt;
  sfl_op_kind_t      kind;
  logic [ADDR_W-1:0] sweepAddr;
  logic [ADDR_W:0]   sweepLeft;
  logic [31:0]       timer;
  logic              csHigh;
  logic              sclkRise;
  logic              sclkFall;
  logic              csRise;
  logic              byteDone;
  logic [7:0]        newByte;
  logic [ADDR_W-1:0] addrM;
  logic              start;
  sfl_op_kind_t      startKind;
  int                startBits;
  int                startCyc;
  // two-stage synchronisers for the link pins
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      csSync   <= 2'h3;
      sclkSync <= 2'h0;
      sinSync  <= 2'h0;
      sclkPrev <= 1'b0;
      csPrev   <= 1'b1;
    end else begin
      csSync   <= {csSync[0], link.csN};
      sclkSync <= {sclkSync[0], link.sclk};
      sinSync  <= {sinSync[0], link.serialIn};
      sclkPrev <= sclkSync[1];
      csPrev   <= csSync[1];
    end
  end
  // edge detection and byte assembly
  assign csHigh   = csSync[1];
  assign sclkRise = sclkSync[1] & ~sclkPrev & ~csHigh;
  assign sclkFall = ~sclkSync[1] & sclkPrev & ~csHigh;
  assign csRise   = csHigh & ~csPrev;
  assign byteDone = sclkRise && (bitCnt == 3'h7);
  assign newByte  = {shiftIn, sinSync[1]};
  assign addrM    = addr[ADDR_W-1:0];
  // frame decoder and read shifter
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state             <= DS_CMD;
      bitCnt            <= 3'h0;
      shiftIn           <= 7'h00;
      opcode            <= 8'h00;
      addr              <= 24'h000000;
      addrCnt           <= 2'h0;
      col               <= 8'h00;
      dataSeen          <= 1'b0;
      rdByte            <= 8'h00;
      outCnt            <= 3'h0;
      link.serialOut    <= 1'b0;
      link.serialOutOeN <= 1'b1;
    end else if (csHigh) begin
      state             <= DS_CMD;
      bitCnt            <= 3'h0;
      addrCnt           <= 2'h0;
      dataSeen          <= 1'b0;
      outCnt            <= 3'h0;
      link.serialOutOeN <= 1'b1;
    end else begin
      if (sclkRise) begin
        shiftIn <= newByte[6:0];
        bitCnt  <= bitCnt + 3'h1;
        if (state == DS_TAIL)
          state <= DS_SKIP;
      end
      if (byteDone) begin
        unique case (state)
          DS_CMD: begin
            opcode <= newByte;
            if (busyFlag)
              state <= DS_SKIP;
            else if (newByte == `SFL_OP_FAST_READ)
              state <= DS_ADDR;
            else if (newByte == `SFL_OP_PAGE_WRITE || newByte == `SFL_OP_SMALL_ERASE ||
                     newByte == `SFL_OP_LARGE_ERASE)
              state <= writeUnlockLatch ? DS_ADDR : DS_SKIP;
            else if (newByte == `SFL_OP_CHIP_ERASE_A || newByte == `SFL_OP_CHIP_ERASE_B)
              state <= writeUnlockLatch ? DS_TAIL : DS_SKIP;
            else if (newByte == `SFL_OP_WRITE_UNLOCK)
              state <= DS_TAIL;
            else
              state <= DS_SKIP;
          end
          DS_ADDR: begin
            addr    <= {addr[15:0], newByte};
            addrCnt <= addrCnt + 2'h1;
            if (addrCnt == 2'h2) begin
              if (opcode == `SFL_OP_FAST_READ)
                state <= DS_DUMMY;
              else if (opcode == `SFL_OP_PAGE_WRITE) begin
                state <= DS_DATA;
                col   <= newByte;
              end else
                state <= DS_TAIL;
            end
          end
          DS_DUMMY: begin
            rdByte            <= mem[addrM];
            addr              <= 24'(addrM + 1'b1);
            state             <= DS_READ;
            link.serialOutOeN <= 1'b0;
          end
          DS_DATA: begin
            col      <= col + 8'h01;
            dataSeen <= 1'b1;
          end
          default: ;
        endcase
      end
      if (sclkFall && state == DS_READ) begin
        link.serialOut <= rdByte[7];
        outCnt         <= outCnt + 3'h1;
        if (outCnt == 3'h7) begin
          rdByte <= mem[addrM];
          addr   <= 24'(addrM + 1'b1);
        end else
          rdByte <= {rdByte[6:0], 1'b0};
      end
    end
  end
  // page buffer: bytes overwrite in page order, only received bytes marked
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)
      pageValid <= '0;
    else if (byteDone && state == DS_ADDR && addrCnt == 2'h2)
      pageValid <= '0;
    else if (byteDone && state == DS_DATA)
      pageValid[col] <= 1'b1;
  end
  always_ff @(posedge sys_clk) begin
    if (byteDone && state == DS_DATA)
      pageBuf[col] <= newByte;
  end
  // commit check at chip select release
  always_comb begin
    start     = 1'b0;
    startKind = OP_PROG;
    startBits = `SFL_PAGE_BITS;
    startCyc  = PROG_CYC;
    if (csRise && !busyFlag) begin
      if (state == DS_DATA && bitCnt == 3'h0 && dataSeen &&
          !isProtected(protectRange, addrM)) begin
        start = 1'b1;
      end else if (state == DS_TAIL && bitCnt == 3'h0) begin
        if (opcode == `SFL_OP_SMALL_ERASE && !isProtected(protectRange, addrM)) begin
          start     = 1'b1;
          startKind = OP_SMALL;
          startBits = `SFL_SECTOR_BITS;
          startCyc  = SMALL_CYC;
        end else if (opcode == `SFL_OP_LARGE_ERASE && !isProtected(protectRange, addrM)) begin
          start     = 1'b1;
          startKind = OP_LARGE;
          startBits = `SFL_BLOCK_BITS;
          startCyc  = LARGE_CYC;
        end else if ((opcode == `SFL_OP_CHIP_ERASE_A || opcode == `SFL_OP_CHIP_ERASE_B) &&
                     protectRange == 3'h0) begin
          start     = 1'b1;
          startKind = OP_CHIP;
          startBits = ADDR_W;
          startCyc  = CHIP_CYC;
        end
      end
    end
  end
  // write-unlock latch
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)
      writeUnlockLatch <= 1'b0;
    else if (start)
      writeUnlockLatch <= 1'b0;
    else if (byteDone && state == DS_CMD && !busyFlag && newByte == `SFL_OP_WRITE_UNLOCK)
      writeUnlockLatch <= 1'b1;
  end
  // self-timed cycle: timer plus a sweep of the region, SWEEP_N bytes per clock
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      busyFlag  <= 1'b0;
      kind      <= OP_PROG;
      sweepAddr <= '0;
      sweepLeft <= '0;
      timer     <= 32'h0;
    end else if (start) begin
      busyFlag <= 1'b1;
      kind     <= startKind;
      timer     <= 32'(startCyc);
      sweepAddr <= addrM & ~ADDR_W'((1 << startBits) - 1);
      sweepLeft <= (ADDR_W+1)'(1) << startBits;
    end else if (busyFlag) begin
      if (timer != 32'h0)
        timer <= timer - 32'h1;
      if (sweepLeft != '0) begin
        sweepAddr <= sweepAddr + ADDR_W'(SWEEP_N);
        sweepLeft <= sweepLeft - (ADDR_W+1)'(SWEEP_N);
      end
      if (timer == 32'h0 && sweepLeft == '0)
        busyFlag <= 1'b0;
    end
  end
  // array update: programming only clears bits, erase sets the byte
  always_ff @(posedge sys_clk) begin
    if (busyFlag && sweepLeft != '0) begin
      for (int k = 0; k < SWEEP_N; k++) begin
        if (kind != OP_PROG)
          mem[sweepAddr + k[ADDR_W-1:0]] <= `SFL_ERASED_BYTE;
        else if (pageValid[sweepAddr[`SFL_PAGE_BITS-1:0] + k[`SFL_PAGE_BITS-1:0]])
          mem[sweepAddr + k[ADDR_W-1:0]] <= mem[sweepAddr + k[ADDR_W-1:0]] &
            pageBuf[sweepAddr[`SFL_PAGE_BITS-1:0] + k[`SFL_PAGE_BITS-1:0]];
      end
    end
  end
endmodule
`default_nettype wire

// >>> sfl_host.sv
// Purpose: host controller driving the flash link, ordered over Avalon-MM
// Assumes: HALF_SCLK >= 4 so returned data settles through the synchroniser
// Notes: waitrequest holds each access until its link work has finished
`timescale 1ns/1ps
`default_nettype none
`include "sfl_params.svh"
module sfl_host
  import sfl_pkg::*;
#(
  parameter int HALF_SCLK = `SFL_HALF_SCLK
) (
  input  wire logic        sys_clk,          // system clock
  input  wire logic        reset_n,          // async reset, active low
  sfl_if.host              link,             // serial link
  input  wire logic [7:0]  avs_address,      // byte address
  input  wire logic        avs_read,         // read request
  input  wire logic        avs_write,        // write request
  input  wire logic [31:0] avs_writedata,    // write data
  output logic      [31:0] avs_readdata,     // read data, registered
  output logic             avs_waitrequest   // stall
);
  initial begin
    if (HALF_SCLK < 4)
      $error("HALF_SCLK below 4 cannot return read data in time");
  end

  sfl_host_state_t state;
  logic [1:0]      soSync;
  logic [15:0]     tickCnt;
  logic            tick;
  logic            launched;
  logic            launch;
  logic [23:0]     addrReg;
  logic [39:0]     txSh;
  logic [2:0]      byteLeft;
  logic [2:0]      bitCnt;
  logic [6:0]      rxSh;
  logic            rxOp;
  logic            gapDone;
  logic            settled;

  // returned data synchroniser
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)
      soSync <= 2'h0;
    else
      soSync <= {soSync[0], link.serialOut};
  end

  // bus handshake
  assign settled         = (state == HS_IDLE) || (state == HS_HOLD);
  assign launch          = (avs_read | avs_write) & ~launched & settled;
  assign avs_waitrequest = (avs_read | avs_write) & ~(launched & settled);
  assign tick            = (tickCnt == 16'(HALF_SCLK - 1));
  assign link.serialIn   = txSh[39];

  // half-period divider, restarted at each launch
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)
      tickCnt <= 16'h0;
    else if (launch || tick)
      tickCnt <= 16'h0;
    else
      tickCnt <= tickCnt + 16'h1;
  end

  // frame sequencer: chip select low through the whole frame
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state        <= HS_IDLE;
      launched     <= 1'b0;
      addrReg      <= 24'h000000;
      txSh         <= 40'h0;
      byteLeft     <= 3'h0;
      bitCnt       <= 3'h0;
      rxSh         <= 7'h00;
      rxOp         <= 1'b0;
      gapDone      <= 1'b0;
      link.csN     <= 1'b1;
      link.sclk    <= 1'b0;
      avs_readdata <= 32'h0;
    end else begin
      if (launched && settled)
        launched <= 1'b0;
      if (launch) begin
        launched <= 1'b1;
        if (avs_read)
          avs_readdata <= 32'h0;
        unique case (avs_address)
          `SFL_REG_CMD: if (avs_write && state == HS_IDLE) begin
            txSh     <= {avs_writedata[7:0], addrReg, 8'h00};
            byteLeft <= 3'(3'h1 + (avs_writedata[`SFL_CMD_WITH_ADDR] ? 3'h3 : 3'h0)
                        + (avs_writedata[`SFL_CMD_WITH_DUMMY] ? 3'h1 : 3'h0));
            rxOp     <= 1'b0;
            state    <= HS_SHIFT;
            link.csN <= 1'b0;
          end
          `SFL_REG_ADDR: if (avs_write)
            addrReg <= avs_writedata[23:0];
          `SFL_REG_TXDATA: if (avs_write && state == HS_HOLD) begin
            txSh     <= {avs_writedata[7:0], 32'h0};
            byteLeft <= 3'h1;
            rxOp     <= 1'b0;
            state    <= HS_SHIFT;
          end
          `SFL_REG_RXDATA: if (avs_read && state == HS_HOLD) begin
            txSh     <= 40'h0;
            byteLeft <= 3'h1;
            rxOp     <= 1'b1;
            state    <= HS_SHIFT;
          end
          `SFL_REG_END: if (avs_write && state == HS_HOLD) begin
            state    <= HS_END;
            gapDone  <= 1'b0;
            link.csN <= 1'b1;
          end
          `SFL_REG_STATUS: if (avs_read)
            avs_readdata[`SFL_STAT_IN_FRAME] <= (state == HS_HOLD);
          default: ;
        endcase
      end else if (tick) begin
        unique case (state)
          HS_SHIFT: begin
            link.sclk <= ~link.sclk;
            if (link.sclk) begin
              rxSh   <= {rxSh[5:0], soSync[1]};
              txSh   <= {txSh[38:0], 1'b0};
              bitCnt <= bitCnt + 3'h1;
              if (bitCnt == 3'h7) begin
                byteLeft <= byteLeft - 3'h1;
                if (rxOp)
                  avs_readdata <= {24'h0, rxSh, soSync[1]};
                if (byteLeft == 3'h1)
                  state <= HS_HOLD;
              end
            end
          end
          HS_END: begin
            gapDone <= 1'b1;
            if (gapDone)
              state <= HS_IDLE;
          end
          default: ;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// >>> sfl_sva.sv
// Purpose: link and flag checker for the flash host and device pair
// Assumes: one sys_clk domain, link wires seen as plain inputs
// Notes: instantiated beside the link interface in the bench
`timescale 1ns/1ps
`default_nettype none
module sfl_sva (
  input wire logic sys_clk,          // system clock
  input wire logic reset_n,          // async reset, active low
  input wire logic csN,              // chip select
  input wire logic sclk,             // serial clock
  input wire logic serialIn,         // host data
  input wire logic serialOut,        // device data
  input wire logic serialOutOeN,     // device enable, active low
  input wire logic busyFlag,         // busy flag
  input wire logic writeUnlockLatch  // write unlock latch
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // link timing and commit relations
  property p_in_stable; sclk && $past(sclk) |-> $stable(serialIn); endproperty
  a_in_stable: assert property (p_in_stable) else $error("data in moved with clock high");
  property p_cs_release; $rose(csN) |-> ##[0:5] serialOutOeN; endproperty
  a_cs_release: assert property (p_cs_release) else $error("output kept after deselect");
  property p_no_read_busy; busyFlag |-> serialOutOeN; endproperty
  a_no_read_busy: assert property (p_no_read_busy) else $error("output driven while busy");
  property p_busy_latch; $rose(busyFlag) |-> $past(writeUnlockLatch); endproperty
  a_busy_latch: assert property (p_busy_latch) else $error("cycle without unlock");
  property p_busy_cs; $rose(busyFlag) |-> csN && $past(csN); endproperty
  a_busy_cs: assert property (p_busy_cs) else $error("cycle before deselect");
  property p_busy_hold; $rose(busyFlag) |-> busyFlag[*8]; endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy too short");
  property p_latch_busy; busyFlag |-> !writeUnlockLatch; endproperty
  a_latch_busy: assert property (p_latch_busy) else $error("latch set during cycle");
  property p_sclk_idle; csN |-> !sclk; endproperty
  a_sclk_idle: assert property (p_sclk_idle) else $error("clock high while deselected");
  property p_cs_edge; $changed(csN) |-> !sclk && !$past(sclk); endproperty
  a_cs_edge: assert property (p_cs_edge) else $error("select moved mid bit");
  // main scenarios reached
  c_cycle: cover property ($rose(busyFlag));
  c_read: cover property ($fell(serialOutOeN));
  c_unlock: cover property ($rose(writeUnlockLatch));
endmodule
`default_nettype wire

// >>> sfl_tb.sv
// Purpose: bench joining flash host and device over the link
// Assumes: short cycle times and a 16-bit array keep the run brief
// Notes: frames are ordered through host registers, flags read directly
`timescale 1ns/1ps
`default_nettype none
`include "sfl_params.svh"
module testbench;
  logic        sys_clk, reset_n, avs_read, avs_write, avs_waitrequest;
  logic        busyFlag, writeUnlockLatch;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [2:0]  protectRange;
  logic [7:0]  d[$];
  int          fail_count, total_checks;
  sfl_if link ();
  sfl_host u_sfl_host (.sys_clk(sys_clk), .reset_n(reset_n), .link(link),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  sfl_device #(.ADDR_W(16), .PROG_TIME_US(1), .SMALL_TIME_US(1), .LARGE_TIME_US(1),
    .CHIP_TIME_US(1)) u_sfl_device (.sys_clk(sys_clk), .reset_n(reset_n), .link(link),
    .protectRange(protectRange), .busyFlag(busyFlag), .writeUnlockLatch(writeUnlockLatch));
  sfl_sva u_sfl_sva (.sys_clk(sys_clk), .reset_n(reset_n), .csN(link.csN), .sclk(link.sclk),
    .serialIn(link.serialIn), .serialOut(link.serialOut), .serialOutOeN(link.serialOutOeN),
    .busyFlag(busyFlag), .writeUnlockLatch(writeUnlockLatch));
  // 50 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic give_verdict();
    $display("checks %0d fails %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // one bus access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] v);
    int n;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= v;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 3000);
    if (n >= 3000) begin
      fail_count++;
      give_verdict();
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic cmd(input logic [7:0] op, input logic [23:0] a, input logic [1:0] f);
    bus(1'b1, `SFL_REG_ADDR, {8'h00, a});
    bus(1'b1, `SFL_REG_CMD, {22'h0, f, op});
  endtask
  // whole frame: command, data bytes, deselect
  task automatic frame(input logic [7:0] op, input logic [23:0] a, input logic [1:0] f,
                       input logic [7:0] b[$]);
    cmd(op, a, f);
    foreach (b[i]) bus(1'b1, `SFL_REG_TXDATA, {24'h0, b[i]});
    bus(1'b1, `SFL_REG_END, 32'h0);
  endtask
  task automatic unlock();
    frame(`SFL_OP_WRITE_UNLOCK, 24'h0, 2'b00, '{});
    chk("latch", 32'h1, {31'h0, writeUnlockLatch});
  endtask
  task automatic cyc();
    int n;
    n = 0;
    while (busyFlag !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    chk("busy", 32'h1, {31'h0, busyFlag});
    chk("latch", 32'h0, {31'h0, writeUnlockLatch});
    while (busyFlag !== 1'b0 && n < 40000) begin
      @(negedge sys_clk);
      n++;
    end
    chk("idle", 32'h0, {31'h0, busyFlag});
  endtask
  task automatic nocyc(input logic l);
    repeat (10) @(negedge sys_clk);
    chk("busy", 32'h0, {31'h0, busyFlag});
    chk("latch", {31'h0, l}, {31'h0, writeUnlockLatch});
  endtask
  task automatic fread(input logic [23:0] a, input logic [7:0] e[$]);
    cmd(`SFL_OP_FAST_READ, a, 2'b11);
    foreach (e[i]) begin
      bus(1'b0, `SFL_REG_RXDATA, 32'h0);
      chk("rdata", {24'h0, e[i]}, q);
    end
    bus(1'b1, `SFL_REG_END, 32'h0);
  endtask
  initial begin
    reset_n = 1'b0;
    {avs_read, avs_write, avs_address, avs_writedata, protectRange} = '0;
    fail_count = 0;
    total_checks = 0;
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    bus(1'b0, 8'h18, 32'h1);
    chk("unmapped", 32'h0, q);
    for (int j = 0; j < 2; j++) begin
      unlock();
      frame(j ? `SFL_OP_CHIP_ERASE_B : `SFL_OP_CHIP_ERASE_A, 24'h0, 2'b00, '{});
      cmd(`SFL_OP_FAST_READ, 24'h0, 2'b11);
      bus(1'b0, `SFL_REG_STATUS, 32'h0);
      chk("inframe", 32'h1, q);
      bus(1'b0, `SFL_REG_RXDATA, 32'h0);
      chk("oe", 32'h1, {31'h0, link.serialOutOeN});
      bus(1'b1, `SFL_REG_END, 32'h0);
      cyc();
    end
    $display("test chip erase done");
    frame(`SFL_OP_PAGE_WRITE, 24'h000100, 2'b01, '{8'h00});
    nocyc(1'b0);
    unlock();
    frame(`SFL_OP_PAGE_WRITE, 24'h0000fe, 2'b01, '{8'ha1, 8'ha2, 8'ha3});
    cyc();
    fread(24'h00ffff, '{8'hff, 8'ha3, 8'hff});
    fread(24'h0000fd, '{8'hff, 8'ha1, 8'ha2, 8'hff});
    $display("test page wrap done");
    unlock();
    for (int i = 0; i < 258; i++) d.push_back(i < 256 ? 8'h11 : 8'h22);
    frame(`SFL_OP_PAGE_WRITE, 24'h001200, 2'b01, d);
    cyc();
    fread(24'h001200, '{8'h22, 8'h22, 8'h11});
    $display("test long page done");
    unlock();
    frame(`SFL_OP_PAGE_WRITE, 24'h001300, 2'b01, '{});
    nocyc(1'b1);
    frame(`SFL_OP_SMALL_ERASE, 24'h001300, 2'b01, '{8'h00});
    nocyc(1'b1);
    frame(`SFL_OP_CHIP_ERASE_A, 24'h0, 2'b01, '{});
    nocyc(1'b1);
    @(posedge sys_clk);
    protectRange <= 3'h1;
    d = '{8'h00};
    frame(`SFL_OP_PAGE_WRITE, 24'h001200, 2'b01, d);
    nocyc(1'b1);
    frame(`SFL_OP_SMALL_ERASE, 24'h001200, 2'b01, '{});
    nocyc(1'b1);
    frame(`SFL_OP_LARGE_ERASE, 24'h001200, 2'b01, '{});
    nocyc(1'b1);
    frame(`SFL_OP_CHIP_ERASE_B, 24'h0, 2'b00, '{});
    nocyc(1'b1);
    fread(24'h001200, '{8'h22});
    @(posedge sys_clk);
    protectRange <= 3'h0;
    $display("test refusals done");
    frame(`SFL_OP_SMALL_ERASE, 24'h000abc, 2'b01, '{});
    cyc();
    fread(24'h0000fe, '{8'hff, 8'hff});
    fread(24'h001200, '{8'h22});
    unlock();
    frame(`SFL_OP_LARGE_ERASE, 24'h002345, 2'b01, '{});
    cyc();
    fread(24'h001200, '{8'hff});
    $display("test erases done");
    give_verdict();
  end
endmodule
`default_nettype wire
